// [rtl/clock_and_stopwatch_timers.sv]
// Clock timer and stopwatch with APB register access
//
// What this block does
// - Seven-bit divider counts the 256 Hz tick.
// - Falling 32, 8, 2 Hz taps raise events.
// - Taps 16 to 2 Hz read-only, reset zero.
// - Three clock-timer enables, readable, reset zero.
// - Flags set on falling edge regardless of mask.
// - Clock-timer flags clear when read; reset zero.
// - Restart write clears divider; reads as zero.
// - Restart may leave a flag; software reads it.
// - Divider 2 Hz output clocks the watchdog.
// - Stopwatch is two cascaded BCD digits.
// - Hundredths step every two or three ticks.
// - Tenths get 25/26 tick decades four to six.
// - Nine-to-zero rolls set 10 Hz, 1 Hz flags.
// - Two stopwatch enables, readable, reset zero.
// - Stopwatch flags clear when read; writes ignored.
// - Both digits read-only, zero after reset.
// - Clear write zeroes digits; same write loads run bit.
// - Run bit starts and stops; digits hold.
// - Carry may tear a running read.
`timescale 1ns/1ns
`default_nettype none
`include "clock_stopwatch_map.svh"
module clock_and_stopwatch_timers
    import clock_stopwatch_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  tick256,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       irq,
    output logic                       watchdogClock
);
    if (ADDR_WIDTH < 12) begin : g_chk
        $error("ADDR_WIDTH must be at least 12");
    end

    logic [`DIV_BITS-1:0] div_r;
    ct_bits_type          ctPrev_r;
    ct_bits_type          ctFall;
    ct_bits_type          ctFlags_r;
    ct_bits_type          ctEn_r;
    ct_bits_type          ctClr;
    sw_bits_type          swFlags_r;
    sw_bits_type          swEn_r;
    sw_bits_type          swClr;
    sw_bits_type          swWrap;
    logic                 run_r;
    logic [1:0]           sub_r;
    logic                 longDecade;
    logic                 longStep;
    logic                 advance;
    logic [3:0]           hund;
    logic [3:0]           tenths;
    logic [9:0]           idx;
    logic                 setup;
    logic                 rdDone;
    logic                 wrDone;
    logic                 hit;
    logic [3:0]           readNibble;
    logic                 restartWr;
    logic                 clearWr;

    // Register index lives in word address bits
    assign idx    = paddr[11:2];
    assign setup  = psel & ~penable;
    assign rdDone = psel & penable & pready & ~pwrite;
    assign wrDone = psel & penable & pready & pwrite;

    assign restartWr = wrDone & (idx == `IDX_CTRL) & pwdata[`BIT_RESTART];
    assign clearWr = wrDone & (idx == `IDX_CTRL) & pwdata[`BIT_CLEAR];

    always_ff @(posedge clock) begin
        if (rst) begin
            div_r <= '0;
        end else if (restartWr) begin
            div_r <= '0;
        end else if (tick256) begin
            div_r <= `DIV_BITS'(div_r + 1'b1);
        end
    end

    // watchdog count clock is the 2 Hz tap
    assign watchdogClock = div_r[`TAP_2HZ];

    always_ff @(posedge clock) begin
        if (rst) begin
            ctPrev_r <= '0;
        end else begin
            ctPrev_r <= '{div_r[`TAP_2HZ], div_r[`TAP_8HZ], div_r[`TAP_32HZ]};
        end
    end

    // falling edges of the three taps
    assign ctFall.f2  = ctPrev_r.f2 & ~div_r[`TAP_2HZ];
    assign ctFall.f8  = ctPrev_r.f8 & ~div_r[`TAP_8HZ];
    assign ctFall.f32 = ctPrev_r.f32 & ~div_r[`TAP_32HZ];

    // clear only what the finished read returned
    assign ctClr = (rdDone && idx == `IDX_CTFLAGS) ? ct_bits_type'(prdata[2:0]) : '0;
    assign swClr = (rdDone && idx == `IDX_SWFLAGS) ? sw_bits_type'(prdata[1:0]) : '0;

    // set wins over read clear, mask ignored
    always_ff @(posedge clock) begin
        if (rst) begin
            ctFlags_r <= '0;
        end else begin
            ctFlags_r <= (ctFlags_r & ~ctClr) | ctFall;
        end
    end

    // digit rolls set the stopwatch flags
    always_ff @(posedge clock) begin
        if (rst) begin
            swFlags_r <= '0;
        end else begin
            swFlags_r <= (swFlags_r & ~swClr) | swWrap;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctEn_r <= '0;
        end else if (wrDone && idx == `IDX_CTEN) begin
            ctEn_r <= ct_bits_type'(pwdata[2:0]);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            swEn_r <= '0;
        end else if (wrDone && idx == `IDX_SWEN) begin
            swEn_r <= sw_bits_type'(pwdata[1:0]);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            run_r <= 1'b0;
        end else if (wrDone && idx == `IDX_CTRL) begin
            run_r <= pwdata[`BIT_RUN];
        end
    end

    // request while any enabled flag stands
    always_ff @(posedge clock) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= (|(ctFlags_r & ctEn_r)) | (|(swFlags_r & swEn_r));
        end
    end

    // six long decades at tenths 1,3,5,7,8,9
    assign longDecade = tenths[0] | (tenths == `LONG_DECADE);
    // odd digits take three ticks, digit 8 too when long
    assign longStep = hund[0] | (longDecade & (hund == `LONG_STEP));
    // step ends after two or three ticks
    assign advance = run_r & tick256 & ~clearWr & (sub_r == (longStep ? 2'd2 : 2'd1));

    always_ff @(posedge clock) begin
        if (rst || clearWr) begin
            sub_r <= 2'd0;
        end else if (run_r && tick256) begin
            sub_r <= advance ? 2'd0 : 2'(sub_r + 2'd1);
        end
    end

    bcd_digit #(
        .LAST (`LAST_DIGIT)
    ) u_hund (
        .clock (clock),
        .rst   (rst),
        .clear (clearWr),
        .inc   (advance),
        .digit (hund),
        .wrap  (swWrap.hz10)
    );

    // tenths stage fed by the hundredths carry
    bcd_digit #(
        .LAST (`LAST_DIGIT)
    ) u_tenths (
        .clock (clock),
        .rst   (rst),
        .clear (clearWr),
        .inc   (swWrap.hz10),
        .digit (tenths),
        .wrap  (swWrap.hz1)
    );

    // Read view of each register; reserved bits read zero
    always_comb begin
        hit        = 1'b1;
        readNibble = `NIBBLE_RST;
        case (idx)
            // taps 16 Hz to 2 Hz
            `IDX_TAPS:    readNibble = div_r[`TAP_2HZ:`TAP_16HZ];
            `IDX_HUND:    readNibble = hund;
            // carry between reads is not hidden
            `IDX_TENTHS:  readNibble = tenths;
            `IDX_SWEN:    readNibble = {2'b00, swEn_r};
            `IDX_CTEN:    readNibble = {1'b0, ctEn_r};
            `IDX_CTFLAGS: readNibble = {1'b0, ctFlags_r};
            `IDX_SWFLAGS: readNibble = {2'b00, swFlags_r};
            // restart and clear read as zero
            `IDX_CTRL:    readNibble = {1'b0, run_r, 2'b00};
            default:      hit = 1'b0;
        endcase
    end

    // One wait-free access phase after each setup
    always_ff @(posedge clock) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            prdata <= '0;
        end else if (setup) begin
            prdata <= (pwrite || !hit) ? 32'h0 : {28'h0, readNibble};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup & ~hit;
        end
    end

    // Checking helpers: ticks since last decade and second roll
    logic [4:0] decTicks_r;
    logic [7:0] secTicks_r;

    always_ff @(posedge clock) begin
        if (rst || clearWr) begin
            decTicks_r <= '0;
            secTicks_r <= '0;
        end else if (run_r && tick256) begin
            decTicks_r <= swWrap.hz10 ? 5'd0 : 5'(decTicks_r + 5'd1);
            secTicks_r <= swWrap.hz1 ? 8'd0 : 8'(secTicks_r + 8'd1);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    restart_clears_a: assert property (restartWr |=> div_r == '0)
        else $error("restart did not clear divider");
    tap_read_a: assert property (setup && !pwrite && idx == `IDX_TAPS
        |=> prdata == {28'h0, $past(div_r[`TAP_2HZ:`TAP_16HZ])})
        else $error("tap read mismatch");
    fall_sets_a: assert property ($fell(div_r[`TAP_32HZ]) |=> ctFlags_r.f32)
        else $error("32 Hz fall did not set flag");
    read_clears_a: assert property (rdDone && idx == `IDX_CTFLAGS && ctFall == '0
        |=> (ctFlags_r & $past(prdata[2:0])) == 3'h0)
        else $error("flag read did not clear");
    irq_request_a: assert property ((swFlags_r & swEn_r) != '0 |=> irq)
        else $error("enabled flag without request");
    stopped_hold_a: assert property (!run_r && !clearWr
        |=> $stable(hund) && $stable(tenths)) else $error("stopped digits moved");
    clear_zero_a: assert property (clearWr |=> hund == 4'h0 && tenths == 4'h0)
        else $error("clear left digits nonzero");
    decade_len_a: assert property (swWrap.hz10
        |-> decTicks_r == `DECADE_SHORT || decTicks_r == `DECADE_LONG)
        else $error("decade not 25 or 26 ticks");
    second_len_a: assert property (swWrap.hz1 |-> secTicks_r == `SECOND_LAST)
        else $error("second not 256 ticks");
    tenths_flag_a: assert property (swWrap.hz1 |=> swFlags_r.hz1)
        else $error("1 Hz flag not set");
    hund_flag_a: assert property (swWrap.hz10 |=> swFlags_r.hz10)
        else $error("10 Hz flag not set");
    fall8_sets_a: assert property ($fell(div_r[`TAP_8HZ]) |=> ctFlags_r.f8)
        else $error("8 Hz fall did not set flag");
    fall2_sets_a: assert property ($fell(div_r[`TAP_2HZ]) |=> ctFlags_r.f2)
        else $error("2 Hz fall did not set flag");
    div_count_a: assert property (tick256 && !restartWr
        |=> div_r == `DIV_BITS'($past(div_r) + 1'b1))
        else $error("divider missed a tick");
    div_hold_a: assert property (!tick256 && !restartWr |=> $stable(div_r))
        else $error("divider moved without tick");

    // Bus-side effects of writes and reads
    sw_read_clears_a: assert property (rdDone && idx == `IDX_SWFLAGS && swWrap == '0
        |=> (swFlags_r & $past(prdata[1:0])) == 2'h0)
        else $error("stopwatch flag read did not clear");
    ct_flag_wr_a: assert property (wrDone && idx == `IDX_CTFLAGS
        |=> ctFlags_r == ($past(ctFlags_r) | $past(ctFall)))
        else $error("clock flag write took effect");
    sw_flag_wr_a: assert property (wrDone && idx == `IDX_SWFLAGS
        |=> swFlags_r == ($past(swFlags_r) | $past(swWrap)))
        else $error("stopwatch flag write took effect");
    ct_enable_wr_a: assert property (wrDone && idx == `IDX_CTEN
        |=> ctEn_r == $past(pwdata[2:0])) else $error("clock enables not written");
    sw_enable_wr_a: assert property (wrDone && idx == `IDX_SWEN
        |=> swEn_r == $past(pwdata[1:0])) else $error("stopwatch enables not written");
    run_wr_a: assert property (wrDone && idx == `IDX_CTRL
        |=> run_r == $past(pwdata[`BIT_RUN])) else $error("run bit not written");
    irq_ct_a: assert property ((ctFlags_r & ctEn_r) != '0 |=> irq)
        else $error("enabled clock flag without request");
    irq_quiet_a: assert property ((ctFlags_r & ctEn_r) == '0 && (swFlags_r & swEn_r) == '0
        |=> !irq) else $error("request without enabled flag");
    hund_read_a: assert property (setup && !pwrite && idx == `IDX_HUND
        |=> prdata == {28'h0, $past(hund)}) else $error("hundredths read mismatch");
    tenths_read_a: assert property (setup && !pwrite && idx == `IDX_TENTHS
        |=> prdata == {28'h0, $past(tenths)}) else $error("tenths read mismatch");
    ctrl_read_a: assert property (setup && !pwrite && idx == `IDX_CTRL
        |=> prdata == {28'h0, 1'b0, $past(run_r), 2'b00})
        else $error("control read mismatch");

    restart_c: cover property (restartWr);
    second_c: cover property (swWrap.hz1);
    flag_clear_c: cover property (rdDone && idx == `IDX_SWFLAGS && prdata != 32'h0);
    bad_addr_c: cover property (pslverr && pready);
    clear_run_c: cover property (clearWr && pwdata[`BIT_RUN]);
endmodule
`default_nettype wire

// [rtl/clock_stopwatch_map.svh]
// Register indices, field positions and reset values of the timers
`ifndef CLOCK_STOPWATCH_MAP_SVH
`define CLOCK_STOPWATCH_MAP_SVH
`define IDX_TAPS     10'h2E0
`define IDX_HUND     10'h2E1
`define IDX_TENTHS   10'h2E2
`define IDX_SWEN     10'h2E6
`define IDX_CTEN     10'h2E8
`define IDX_CTFLAGS  10'h2E9
`define IDX_SWFLAGS  10'h2EA
`define IDX_CTRL     10'h2EE
`define BIT_RESTART  3
`define BIT_RUN      2
`define BIT_CLEAR    1
`define TAP_32HZ     2
`define TAP_16HZ     3
`define TAP_8HZ      4
`define TAP_2HZ      6
`define DIV_BITS     7
`define LAST_DIGIT   4'h9
`define LONG_DECADE  4'h8
`define LONG_STEP    4'h8
`define NIBBLE_RST   4'h0
`define DECADE_SHORT 5'd24
`define DECADE_LONG  5'd25
`define SECOND_LAST  8'hFF
`endif

// [rtl/clock_stopwatch_pkg.sv]
// Types shared by the clock timer and stopwatch
package clock_stopwatch_pkg;
    typedef struct packed {
        logic f2;
        logic f8;
        logic f32;
    } ct_bits_type;
    typedef struct packed {
        logic hz1;
        logic hz10;
    } sw_bits_type;
endpackage

// [rtl/bcd_digit.sv]
// One decimal counting stage with clear and wrap output
`timescale 1ns/1ns
`default_nettype none
module bcd_digit #(
    parameter logic [3:0] LAST = 4'h9
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       clear,
    input  wire logic       inc,
    output logic [3:0]      digit,
    output logic            wrap
);
    if (LAST == 4'h0) begin : g_chk
        $error("LAST must be above zero");
    end

    // Wrap pulse marks the step from LAST to zero
    assign wrap = inc & ~clear & (digit == LAST);

    always_ff @(posedge clock) begin
        if (rst || clear) begin
            digit <= 4'h0;
        end else if (inc) begin
            digit <= (digit == LAST) ? 4'h0 : 4'(digit + 4'h1);
        end
    end

    digit_range_a: assert property (@(posedge clock) disable iff (rst)
        digit <= LAST) else $error("digit beyond last value");
    wrap_to_zero_a: assert property (@(posedge clock) disable iff (rst)
        wrap |=> digit == 4'h0) else $error("wrap did not return to zero");
endmodule
`default_nettype wire

// [testbench/cpu_partner.sv]
// Processor-side APB master model for the timer block
`timescale 1ns/1ns
`default_nettype none
module cpu_partner (
    input  wire logic        clock,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic hung);
        int n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        hung = (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// [testbench/clock_and_stopwatch_timers_tb_top.sv]
// Self-checking bench for the clock timer and stopwatch
`timescale 1ns/1ns
`default_nettype none
`include "clock_stopwatch_map.svh"
module clock_and_stopwatch_timers_tb_top;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        tick256 = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, irq, watchdogClock;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int          n_mismatch = 0;
    int          checks = 0;
    int          div = 0, sub = 0, hun = 0, ten = 0, run = 0;
    int          ctf = 0, swf = 0, cten = 0, swen = 0;
    logic [9:0]  regs [8] = '{`IDX_TAPS, `IDX_HUND, `IDX_TENTHS, `IDX_SWEN,
                              `IDX_CTEN, `IDX_CTFLAGS, `IDX_SWFLAGS, `IDX_CTRL};

    always #2 clock = ~clock;

    cpu_partner cpu (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    clock_and_stopwatch_timers dut (.clock(clock), .rst(rst), .tick256(tick256),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .watchdogClock(watchdogClock));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        logic hung;
        cpu.xfer(w, {idx, 2'b00}, d, r, e, hung);
        if (hung) begin
            n_mismatch++;
            finish_test();
        end
    endtask

    task automatic rd(input logic [9:0] idx, input int exp, input logic err);
        logic [31:0] r;
        logic        e;
        bus(1'b0, idx, 32'h0000_0000, r, e);
        check(r, exp);
        check({31'h0, e}, {31'h0, err});
        if (idx == `IDX_CTFLAGS) ctf = 0;
        if (idx == `IDX_SWFLAGS) swf = 0;
    endtask

    // Divider model; falling 32, 8 and 2 Hz taps latch flags
    task automatic setDiv(input int v);
        int f;
        f = div & ~v;
        ctf |= ((f >> 2) & 1) | ((f >> 3) & 2) | ((f >> 4) & 4);
        div = v;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        bus(1'b1, idx, d, r, e);
        if (idx == `IDX_CTEN) cten = d & 7;
        if (idx == `IDX_SWEN) swen = d & 3;
        if (idx == `IDX_CTRL) begin
            if (d[3]) setDiv(0);
            run = d[2];
            if (d[1]) begin
                hun = 0;
                ten = 0;
                sub = 0;
            end
        end
    endtask

    // Stopwatch model: long step on odd digit or on eight in long decades
    task automatic stepSw();
        sub++;
        if (sub == ((hun % 2 == 1 || (hun == 8 && ten inside {1, 3, 5, 7, 8, 9})) ? 3 : 2)) begin
            sub = 0;
            hun++;
            if (hun == 10) begin
                hun = 0;
                swf |= 1;
                ten++;
                if (ten == 10) begin
                    ten = 0;
                    swf |= 2;
                end
            end
        end
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock);
            tick256 <= 1'b1;
            @(posedge clock);
            tick256 <= 1'b0;
            setDiv((div + 1) % 128);
            if (run != 0) stepSw();
            repeat (2) @(posedge clock);
        end
    endtask

    task automatic chkIrq();
        repeat (2) @(posedge clock);
        check({31'h0, irq}, (((ctf & cten) | (swf & swen)) != 0) ? 1 : 0);
    endtask

    initial begin
        void'($urandom(57766));
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 8; i++) rd(regs[i], 0, 1'b0);
        rd(10'h2E3, 0, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 7; i++) wr(regs[i], $urandom);
        for (int i = 0; i < 7; i++) rd(regs[i], (i == 3) ? swen : (i == 4) ? cten : 0, 1'b0);
        $display("test access done");
        wr(`IDX_CTEN, 32'h0000_0007);
        wr(`IDX_SWEN, 32'h0000_0000);
        tick($urandom_range(192, 250));
        rd(`IDX_TAPS, (div >> 3) & 15, 1'b0);
        check({31'h0, watchdogClock}, (div >> 6) & 1);
        chkIrq();
        rd(`IDX_CTFLAGS, ctf, 1'b0);
        rd(`IDX_CTFLAGS, 0, 1'b0);
        chkIrq();
        $display("test clock timer done");
        tick($urandom_range(1, 60));
        wr(`IDX_CTRL, 32'h0000_0008);
        rd(`IDX_TAPS, 0, 1'b0);
        rd(`IDX_CTRL, 0, 1'b0);
        rd(`IDX_CTFLAGS, ctf, 1'b0);
        $display("test restart done");
        wr(`IDX_SWEN, 32'h0000_0003);
        wr(`IDX_CTEN, 32'h0000_0000);
        wr(`IDX_CTRL, 32'h0000_0004);
        tick($urandom_range(256, 300));
        rd(`IDX_HUND, hun, 1'b0);
        rd(`IDX_TENTHS, ten, 1'b0);
        chkIrq();
        rd(`IDX_SWFLAGS, swf, 1'b0);
        rd(`IDX_CTRL, 4, 1'b0);
        rd(`IDX_TAPS, (div >> 3) & 15, 1'b0);
        wr(`IDX_CTRL, 32'h0000_0000);
        tick(20);
        rd(`IDX_HUND, hun, 1'b0);
        wr(`IDX_CTRL, 32'h0000_0002);
        tick(5);
        rd(`IDX_HUND, 0, 1'b0);
        rd(`IDX_TENTHS, 0, 1'b0);
        wr(`IDX_CTRL, 32'h0000_0006);
        tick(25);
        rd(`IDX_HUND, hun, 1'b0);
        rd(`IDX_TENTHS, ten, 1'b0);
        rd(`IDX_SWFLAGS, swf, 1'b0);
        chkIrq();
        rd(`IDX_CTFLAGS, ctf, 1'b0);
        $display("test stopwatch done");
        finish_test();
    end
endmodule
`default_nettype wire
